// *** rmpu_pkg.sv ***
// Constants, types and field layout for the region memory protection unit
// Overview of operation
// - Disabled unit: default map, no region faults
// - Privileged miss uses default map when enabled
// - Unprivileged miss faults while protection enabled
// - System control space always execute-never, ordered
// - System space and vector data accesses always permitted
// - Escalated handlers bypass unless enable bit set
// - Region select holds bits 7:0, 0-255, bits 2:0 pick the region
// - Base write with valid updates select, base
// - Base write without valid uses current select
// - Base read: valid zero, select in field
// - Base field bits 31:N, size aligned
// - Full-map size ignores base field
// - Attribute register takes word and halfword writes
// - Execute-never bit blocks instruction fetches
// - Subregion disable bit removes one eighth
// - Size is two to size plus one
// - Highest numbered overlapping region wins
// - Permission 000 none, 011 full access
package rmpu_pkg;
  localparam int RMPU_NREG = 8;
  localparam logic [5:0] RMPU_IDX_CTRL = 6'h00;
  localparam logic [5:0] RMPU_IDX_SEL = 6'h01;
  localparam logic [5:0] RMPU_IDX_BASE = 6'h02;
  localparam logic [5:0] RMPU_IDX_ATTR = 6'h03;
  localparam logic [5:0] RMPU_IDX_FSTAT = 6'h04;
  localparam logic [5:0] RMPU_IDX_FADDR = 6'h05;
  localparam int RMPU_CTRL_EN = 0;
  localparam int RMPU_CTRL_HFE = 1;
  localparam int RMPU_CTRL_BGE = 2;
  localparam int RMPU_BASE_VALID = 4;
  localparam int RMPU_BASE_LO = 5;
  localparam int RMPU_ATTR_XN = 28;
  localparam int RMPU_ATTR_AP = 24;
  localparam int RMPU_ATTR_TEX = 19;
  localparam int RMPU_ATTR_S = 18;
  localparam int RMPU_ATTR_C = 17;
  localparam int RMPU_ATTR_B = 16;
  localparam int RMPU_ATTR_SRD = 8;
  localparam int RMPU_ATTR_SIZE = 1;
  localparam int RMPU_ATTR_EN = 0;
  localparam logic [31:0] RMPU_ATTR_WMASK = 32'h173f_ff3f;
  localparam logic [4:0] RMPU_SIZE_MIN = 5'h04;
  localparam logic [4:0] RMPU_SIZE_SUB = 5'h07;
  localparam logic [4:0] RMPU_SIZE_FULL = 5'h1f;
  localparam logic [31:0] RMPU_SCS_BASE = 32'he000_e000;
  localparam logic [31:0] RMPU_SCS_MASK = 32'hffff_f000;
  localparam logic [31:0] RMPU_VEC_BASE = 32'h0000_0000;
  localparam logic [31:0] RMPU_VEC_MASK = 32'hffff_fc00;
  localparam logic [2:0] RMPU_AP_NONE = 3'h0;
  localparam logic [2:0] RMPU_AP_PRIV = 3'h1;
  localparam logic [2:0] RMPU_AP_URO = 3'h2;
  localparam logic [2:0] RMPU_AP_FULL = 3'h3;
  localparam logic [2:0] RMPU_AP_PRO = 3'h5;
  localparam logic [2:0] RMPU_AP_RO = 3'h6;
  localparam logic [2:0] RMPU_AP_RO2 = 3'h7;
  localparam logic [31:0] RMPU_RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RMPU_RST_SEL = 8'h00;

  // One access from the core pipeline
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic fetch;
    logic priv;
    logic escalated;
  } rmpu_acc_t;

  // Attributes exported with a granted access
  typedef struct packed {
    logic default_map;
    logic strongly_ordered;
    logic execute_never;
    logic [2:0] type_extension;
    logic s;
    logic c;
    logic b;
  } rmpu_attr_t;
endpackage : rmpu_pkg

// *** rmpu_top.sv ***
// Region memory protection unit with classic Wishbone register slave
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
module rmpu_top
  import rmpu_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire rmpu_acc_t acc,
  output logic acc_grant,
  output logic mem_fault,
  output rmpu_attr_t acc_attr
);
  logic [2:0] ctrl;
  logic [7:0] region_select;
  logic [26:0] base [RMPU_NREG];
  logic [31:0] attr [RMPU_NREG];
  logic [3:0] fstat;
  logic [31:0] faddr;
  logic [RMPU_NREG-1:0] hit;
  logic [31:0] base_view [RMPU_NREG];
  logic win_hit;
  logic [2:0] win;
  logic scs_hit;
  logic vec_hit;
  logic checking;
  logic violation;
  logic wr_en;
  logic req_new;
  logic [31:0] next_word;
  logic [31:0] rd_word;
  logic [2:0] cur;
  logic [2:0] base_tgt;
  rmpu_attr_t next_attr;

  // Byte-lane merge for a write
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // Permission check against one access
  function automatic logic ap_ok(input logic [2:0] ap, input logic priv, input logic wr);
    logic r;
    case (ap)
      RMPU_AP_NONE: r = 1'b0;
      RMPU_AP_PRIV: r = priv;
      RMPU_AP_URO: r = priv | !wr;
      RMPU_AP_FULL: r = 1'b1;
      RMPU_AP_PRO: r = priv & !wr;
      RMPU_AP_RO: r = !wr;
      RMPU_AP_RO2: r = !wr;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : ap_ok

  // Wishbone handshake: answer one cycle after the request is seen
  assign req_new = cyc_i & stb_i & !ack_o;
  assign wr_en = cyc_i & stb_i & ack_o & we_i;
  assign cur = region_select[2:0];
  assign base_tgt = dat_i[RMPU_BASE_VALID] ? dat_i[2:0] : cur;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= req_new;
    end
  end

  // Control bits
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl <= RMPU_RST_WORD[2:0];
    end
    else if (wr_en && adr_i[7:2] == RMPU_IDX_CTRL && sel_i[0])
    begin
      ctrl <= dat_i[2:0];
    end
  end

  // Region select, also moved by a base write with valid set
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      region_select <= RMPU_RST_SEL;
    end
    else if (wr_en && adr_i[7:2] == RMPU_IDX_SEL && sel_i[0])
    begin
      region_select <= dat_i[7:0];
    end
    else if (wr_en && adr_i[7:2] == RMPU_IDX_BASE && dat_i[RMPU_BASE_VALID])
    begin
      region_select <= {4'h0, dat_i[3:0]};
    end
  end

  // Per-region base, attributes and address match
  for (genvar i = 0; i < RMPU_NREG; i++)
  begin : g_reg
    logic [4:0] size;
    logic [5:0] n;
    logic [32:0] mask;
    logic [31:0] sh;
    logic [2:0] sub;
    logic raw;
    assign size = attr[i][RMPU_ATTR_SIZE +: 5];
    // size is two to size plus one
    assign n = {1'b0, size} + 6'h01;
    assign mask = ~((33'h1 << n) - 33'h1);
    assign sh = acc.addr >> (n - 6'h03);
    assign sub = sh[2:0];
    assign base_view[i] = {base[i], 5'h00} & mask[31:0];
    assign raw = attr[i][RMPU_ATTR_EN] && size >= RMPU_SIZE_MIN &&
                 (size == RMPU_SIZE_FULL || ((acc.addr ^ {base[i], 5'h00}) & mask[31:0]) == 0);
    assign hit[i] = raw && !(size >= RMPU_SIZE_SUB && attr[i][RMPU_ATTR_SRD + sub]);

    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        base[i] <= RMPU_RST_WORD[31:5];
        attr[i] <= RMPU_RST_WORD;
      end
      else
      begin
        // no valid bit uses current select
        if (wr_en && adr_i[7:2] == RMPU_IDX_BASE && base_tgt == 3'(i))
        begin
          base[i] <= next_word[31:RMPU_BASE_LO];
        end
        if (wr_en && adr_i[7:2] == RMPU_IDX_ATTR && cur == 3'(i))
        begin
          attr[i] <= next_word & RMPU_ATTR_WMASK;
        end
      end
    end
  end

  // Merged write word for base or attributes of the addressed region
  always_comb
  begin
    if (adr_i[7:2] == RMPU_IDX_BASE)
    begin
      next_word = lane_merge({base[base_tgt], 5'h00}, dat_i, sel_i);
    end
    else
    begin
      next_word = lane_merge(attr[cur], dat_i, sel_i);
    end
  end

  always_comb
  begin
    win_hit = 1'b0;
    win = 3'h0;
    for (int k = 0; k < RMPU_NREG; k++)
    begin
      if (hit[k])
      begin
        win_hit = 1'b1;
        win = 3'(k);
      end
    end
  end

  assign scs_hit = (acc.addr & RMPU_SCS_MASK) == RMPU_SCS_BASE;
  assign vec_hit = (acc.addr & RMPU_VEC_MASK) == RMPU_VEC_BASE;
  assign checking = ctrl[RMPU_CTRL_EN] && (!acc.escalated || ctrl[RMPU_CTRL_HFE]);

  // Access decision
  always_comb
  begin
    if (scs_hit)
    begin
      violation = acc.fetch;
    end
    else if (!checking)
    begin
      violation = 1'b0;
    end
    else if (vec_hit && !acc.fetch)
    begin
      violation = 1'b0;
    end
    else if (win_hit)
    begin
      violation = (acc.fetch && attr[win][RMPU_ATTR_XN]) ||
                  !ap_ok(attr[win][RMPU_ATTR_AP +: 3], acc.priv, acc.write);
    end
    else
    begin
      violation = !(acc.priv && ctrl[RMPU_CTRL_BGE]);
    end
  end

  // fault and suppress in same cycle
  assign mem_fault = acc.valid & violation;
  assign acc_grant = acc.valid & !violation;

  // Attributes of the decided access
  always_comb
  begin
    next_attr = '0;
    if (scs_hit)
    begin
      next_attr.strongly_ordered = 1'b1;
      next_attr.execute_never = 1'b1;
    end
    else if (checking && win_hit && !(vec_hit && !acc.fetch))
    begin
      next_attr.execute_never = attr[win][RMPU_ATTR_XN];
      next_attr.type_extension = attr[win][RMPU_ATTR_TEX +: 3];
      next_attr.s = attr[win][RMPU_ATTR_S];
      next_attr.c = attr[win][RMPU_ATTR_C];
      next_attr.b = attr[win][RMPU_ATTR_B];
      next_attr.strongly_ordered = attr[win][RMPU_ATTR_TEX +: 3] == 3'h0 &&
                                   !attr[win][RMPU_ATTR_C] && !attr[win][RMPU_ATTR_B];
    end
    else
    begin
      next_attr.default_map = 1'b1;
    end
  end

  // Attributes follow the granted access by one cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      acc_attr <= '0;
    end
    else if (acc_grant)
    begin
      acc_attr <= next_attr;
    end
  end

  // Fault record; a new fault wins over a clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fstat <= RMPU_RST_WORD[3:0];
      faddr <= RMPU_RST_WORD;
    end
    else if (mem_fault)
    begin
      fstat <= {acc.priv, acc.fetch, acc.write, 1'b1};
      faddr <= acc.addr;
    end
    else if (wr_en && adr_i[7:2] == RMPU_IDX_FSTAT && sel_i[0] && dat_i[0])
    begin
      fstat <= 4'h0;
    end
  end

  // Read mux; unmapped words read zero
  always_comb
  begin
    case (adr_i[7:2])
      RMPU_IDX_CTRL: rd_word = {29'h0, ctrl};
      RMPU_IDX_SEL: rd_word = {24'h0, region_select};
      // valid reads zero, field shows select
      RMPU_IDX_BASE: rd_word = base_view[cur] | {28'h0, region_select[3:0]};
      RMPU_IDX_ATTR: rd_word = attr[cur];
      RMPU_IDX_FSTAT: rd_word = {28'h0, fstat};
      RMPU_IDX_FADDR: rd_word = faddr;
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dat_o <= RMPU_RST_WORD;
    end
    else if (req_new && !we_i)
    begin
      dat_o <= rd_word;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_answer;
    ack_o ##1 !ack_o;
  endsequence

  a_wb_ack_once: assert property (s_req |=> s_answer)
    else $error("ack not a single pulse after request");
  a_off_no_fault: assert property (acc.valid && !ctrl[RMPU_CTRL_EN] && !scs_hit |-> !mem_fault)
    else $error("fault while unit disabled");
  a_bg_priv_ok: assert property (acc.valid && checking && ctrl[RMPU_CTRL_BGE] && acc.priv &&
                                 !win_hit && !scs_hit |-> acc_grant)
    else $error("privileged background access refused");
  a_unpriv_miss: assert property (acc.valid && checking && !acc.priv && !win_hit && !scs_hit &&
                                  !vec_hit |-> mem_fault)
    else $error("unprivileged miss not faulted");
  a_scs_xn_fetch: assert property (acc.valid && scs_hit |-> mem_fault == acc.fetch)
    else $error("system space fetch rule broken");
  a_escal_bypass: assert property (acc.valid && acc.escalated && !ctrl[RMPU_CTRL_HFE] &&
                                   !scs_hit |-> acc_grant)
    else $error("escalated handler checked");
  a_sel_update: assert property (wr_en && adr_i[7:2] == RMPU_IDX_BASE &&
                                 dat_i[RMPU_BASE_VALID] |=> region_select == {4'h0, $past(dat_i[3:0])})
    else $error("valid base write did not move select");
  a_base_read: assert property ((s_req and (!we_i && adr_i[7:2] == RMPU_IDX_BASE)) |=>
                                !dat_o[4] && dat_o[3:0] == $past(region_select[3:0]))
    else $error("base read field wrong");
  a_xn_fetch: assert property (acc.valid && checking && win_hit && acc.fetch && !scs_hit &&
                               attr[win][RMPU_ATTR_XN] |-> mem_fault)
    else $error("fetch from execute-never region allowed");
  a_fault_excl: assert property (mem_fault |-> !acc_grant ##1 fstat[0])
    else $error("fault granted or not recorded");
endmodule : rmpu_top

// *** rmpu_core_model.sv ***
// Core pipeline stand-in issuing one access at a time
`timescale 1ns/100ps
module rmpu_core_model
  import rmpu_pkg::*;
(
  input wire logic clk,
  input wire logic acc_grant,
  input wire logic mem_fault,
  input wire rmpu_attr_t acc_attr,
  output rmpu_acc_t acc
);
  // Idle until the bench asks for an access
  initial acc = '0;

  // One access: k is write, fetch, priv, escalated
  task automatic issue(input logic [31:0] a, input logic [3:0] k, output logic [1:0] gf,
    output rmpu_attr_t at);
    @(posedge clk);
    acc <= {1'b1, a, k};
    @(negedge clk);
    gf = {acc_grant, mem_fault};
    @(posedge clk);
    // Released lines show the inverse, never the old value
    acc <= {1'b0, ~a, ~k};
    @(negedge clk);
    at = acc_attr;
  endtask : issue
endmodule : rmpu_core_model

// *** test_region_memory_protection_unit.sv ***
// Self-checking bench for the region memory protection unit
`timescale 1ns/100ps
module test_region_memory_protection_unit
  import rmpu_pkg::*;
;
  localparam logic [1:0] G = 2'b10;
  localparam logic [1:0] F = 2'b01;
  logic clk, srst, cyc, stb, we, ack, acc_grant, mem_fault;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, d;
  logic [1:0] gf;
  rmpu_acc_t acc;
  rmpu_attr_t acc_attr, at;
  int n_fail, num_checks;
  integer seed = 32'heb81;

  rmpu_top DUT (.clk(clk), .srst(srst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .acc(acc), .acc_grant(acc_grant),
    .mem_fault(mem_fault), .acc_attr(acc_attr));
  rmpu_core_model core (.clk(clk), .acc_grant(acc_grant), .mem_fault(mem_fault),
    .acc_attr(acc_attr), .acc(acc));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Attribute word with region enabled
  function automatic logic [31:0] mk(logic xn, logic [2:0] ap, logic [7:0] subregion_disable, logic [4:0] sz);
    return {3'h0, xn, 1'b0, ap, 8'h00, subregion_disable, 2'h0, sz, 1'b1};
  endfunction : mk

  // Base read: base cut to region size, select in low bits
  function automatic logic [31:0] base_rd(logic [31:0] b, logic [4:0] sz, logic [3:0] s);
    return (b & (32'hffff_ffff << (int'(sz) + 1))) | {28'h0, s};
  endfunction : base_rd

  // Expected grant or fault from the permission table; reserved code faults
  function automatic logic [1:0] ap_exp(logic [2:0] ap, logic p, logic w);
    logic ok;
    case (ap)
      3'h1: ok = p;
      3'h2: ok = p || !w;
      3'h3: ok = 1'b1;
      3'h5: ok = p && !w;
      3'h6: ok = !w;
      3'h7: ok = !w;
      default: ok = 1'b0;
    endcase
    return ok ? G : F;
  endfunction : ap_exp

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Classic Wishbone single cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
    input logic [3:0] s, output logic [31:0] r);
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, v};
    do @(posedge clk);
    while (ack !== 1'b1);
    r = dat_o;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic [31:0] r;
    wb(1'b1, a, v, s, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, 4'hf, r);
  endtask : rd

  task automatic ck(input logic [31:0] a, input logic [3:0] k, input logic [1:0] e);
    core.issue(a, k, gf, at);
    chk("grant_fault", {30'h0, e}, {30'h0, gf});
  endtask : ck

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    int i;
    int j;
    logic [31:0] r;
    {srst, cyc, stb, we, adr, sel, dat} = {4'b1000, 44'h0};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      rd(8'(i * 4), d);
      chk("reset", 32'h0, d);
    end
    wr(8'h3c, 32'hffff_ffff, 4'hf);
    rd(8'h3c, d);
    chk("unmapped", 32'h0, d);
    // Disabled unit: random data accesses pass
    for (i = 0; i < 8; i++)
    begin
      r = $random(seed);
      ck({4'h2, r[27:0]}, {r[31], 1'b0, r[30], 1'b0}, G);
    end
    ck(32'he000_e010, 4'h6, F);
    for (i = 0; i < 4; i++)
    begin
      r = $random(seed) & 32'h7;
      wr(8'h04, r, 4'hf);
      rd(8'h04, d);
      chk("select", r, d);
    end
    wr(8'h08, 32'h0000_0012, 4'hf);
    rd(8'h04, d);
    chk("select", 32'h2, d);
    wr(8'h0c, mk(1'b1, RMPU_AP_FULL, 8'h00, 5'h09), 4'hf);
    wr(8'h08, 32'h2000_0146, 4'hf);
    rd(8'h04, d);
    chk("select", 32'h2, d);
    rd(8'h08, d);
    chk("base", base_rd(32'h2000_0146, 5'h09, 4'h2), d);
    // Enabled, background map off, later on
    wr(8'h00, 32'h1, 4'hf);
    ck(32'h2000_0100, 4'h0, G);
    ck(32'h2000_03fc, 4'h8, G);
    ck(32'h2000_0400, 4'h0, F);
    ck(32'h2000_0100, 4'h4, F);
    ck(32'he000_e100, 4'h0, G);
    chk("scs_attr", 32'h3, {30'h0, at.strongly_ordered, at.execute_never});
    ck(32'h0000_0100, 4'h8, G);
    ck(32'h4000_0000, 4'h2, F);
    ck(32'h4000_0000, 4'h1, G);
    wr(8'h00, 32'h3, 4'hf);
    ck(32'h4000_0000, 4'h1, F);
    wr(8'h00, 32'h5, 4'hf);
    core.issue(32'h4000_0000, 4'h2, gf, at);
    chk("priv_bg", {29'h0, G, 1'b1}, {29'h0, gf, at.default_map});
    ck(32'h4000_0000, 4'h0, F);
    // Higher region without rights overlaps region 2
    wr(8'h08, 32'h2000_0015, 4'hf);
    wr(8'h0c, mk(1'b0, RMPU_AP_NONE, 8'h00, 5'h07), 4'hf);
    ck(32'h2000_0010, 4'h2, F);
    ck(32'h2000_0200, 4'h0, G);
    wr(8'h08, 32'h3000_0016, 4'hf);
    wr(8'h0c, mk(1'b0, RMPU_AP_FULL, 8'h02, 5'h0b), 4'hf);
    ck(32'h3000_0100, 4'h0, G);
    ck(32'h3000_0300, 4'h0, F);
    wr(8'h0c, 32'h1300_0000, 4'hc);
    ck(32'h3000_0100, 4'h4, F);
    rd(8'h0c, d);
    chk("attr", mk(1'b1, RMPU_AP_FULL, 8'h02, 5'h0b), d);
    // Full map region with junk in the base field
    wr(8'h08, 32'h1234_5617, 4'hf);
    wr(8'h0c, mk(1'b0, RMPU_AP_RO, 8'h00, 5'h1f), 4'hf);
    ck(32'h9abc_0000, 4'h0, G);
    ck(32'hf000_0040, 4'h8, F);
    // Fault record of the last refused write, then cleared
    rd(8'h14, d);
    chk("fault_addr", 32'hf000_0040, d);
    rd(8'h10, d);
    chk("fault_status", 32'h3, d);
    wr(8'h10, 32'h1, 4'hf);
    rd(8'h10, d);
    chk("fault_clear", 32'h0, d);
    // Every permission code on the full-map region, all privilege and direction pairs
    for (i = 0; i < 8; i++)
    begin
      wr(8'h0c, mk(1'b0, 3'(i), 8'h00, 5'h1f), 4'hf);
      for (j = 0; j < 4; j++)
      begin
        ck(32'h9abc_0000, {j[0], 1'b0, j[1], 1'b0}, ap_exp(3'(i), j[1], j[0]));
      end
    end
    give_verdict();
  end
endmodule : test_region_memory_protection_unit
